// ---- logic/usa_fifo.sv ----
// Character FIFO with registered read data, single-entry overwrite mode
`timescale 1ns/1ps
`default_nettype none
module usa_fifo
  import usa_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  flush,
  input  wire logic                  fifo_en,
  input  wire logic                  push,
  input  wire logic [USA_DATA_W-1:0] push_data,
  input  wire logic                  pop,
  output logic      [USA_DATA_W-1:0] rd_data,
  output logic      [USA_CNT_W-1:0]  count,
  output logic                       lost,
  output logic                       replaced
);

  logic [USA_DATA_W-1:0] mem_r [USA_FIFO_DEPTH]; // Storage
  logic [USA_PTR_W-1:0]  head_r;                 // Oldest entry
  logic [USA_PTR_W-1:0]  tail_r;                 // Next free entry
  logic [USA_CNT_W-1:0]  cnt_r;                  // Entries held
  logic                  pop_ok;                 // Pop that takes an entry
  logic                  push_ok;                // Push into a free entry
  logic [USA_PTR_W-1:0]  wr_addr;                // Where a push lands

  // Pops on an empty queue do nothing; a pop in the same cycle frees room
  assign pop_ok   = pop && (cnt_r != '0);
  assign lost     = push && fifo_en && (cnt_r == USA_FIFO_FULL) && !pop_ok;
  assign replaced = push && !fifo_en && (cnt_r != '0) && !pop_ok;
  assign push_ok  = push && !lost && !replaced;
  assign wr_addr  = replaced ? head_r : tail_r;
  assign count    = cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // Storage write, no reset needed
  always_ff @(posedge clk) begin
    if (push_ok || replaced) begin
      mem_r[wr_addr] <= push_data;
    end
  end

  // Registered read of the head entry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (pop_ok) begin
      rd_data <= mem_r[head_r];
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      head_r <= '0;
      tail_r <= '0;
      cnt_r  <= '0;
    end else if (flush) begin
      head_r <= '0;
      tail_r <= '0;
      cnt_r  <= '0;
    end else begin
      if (push_ok) begin
        tail_r <= tail_r + 1'b1;
      end
      if (pop_ok) begin
        head_r <= head_r + 1'b1;
      end
      if (push_ok && !pop_ok) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop_ok && !push_ok) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- logic/usa_pkg.sv ----
// Constants and types shared by the UART shadow alias block
package usa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Address map
  localparam logic [31:0] USA_SLOT8_ADDR     = 32'h5000_1050; // Alias slot 8
  localparam logic [31:0] USA_SLOT9_ADDR     = 32'h5000_1054; // Alias slot 9
  localparam int          USA_SLOT8_INDEX    = 8;             // Index of slot 8
  localparam int          USA_SLOT_STRIDE    = 4;             // Bytes per slot
  localparam int          USA_SLOT_COUNT     = 16;            // Slots in the alias
  localparam logic [31:0] USA_ALIAS_BASE     = USA_SLOT8_ADDR - 32'(USA_SLOT8_INDEX * USA_SLOT_STRIDE);
  localparam logic [31:0] USA_ALIAS_SPAN     = 32'(USA_SLOT_COUNT * USA_SLOT_STRIDE);
  localparam logic [31:0] USA_CTRL_ADDR      = 32'h5000_1100; // Mode control
  localparam logic [31:0] USA_LSTAT_ADDR     = 32'h5000_1104; // Line status
  localparam logic [31:0] USA_DIV_ADDR       = 32'h5000_1108; // Bit period in clocks
  localparam logic [31:0] USA_ISTAT_ADDR     = 32'h5000_110c; // Interrupt status
  localparam logic [31:0] USA_IMASK_ADDR     = 32'h5000_1110; // Interrupt mask

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int          USA_CTRL_FIFO_EN   = 0;  // FIFOs enabled
  localparam int          USA_CTRL_IR_MODE   = 1;  // Infrared mode
  localparam int          USA_CTRL_W         = 2;  // Control width
  localparam int          USA_LS_DATA_VALID  = 0;  // Receive data valid flag
  localparam int          USA_LS_OVERRUN     = 1;  // Overrun error
  localparam int          USA_LS_TX_EMPTY    = 5;  // Transmit holding empty flag
  localparam int          USA_LS_TX_IDLE     = 6;  // Transmitter fully idle
  localparam int          USA_INT_RX         = 0;  // Character received
  localparam int          USA_INT_OVR        = 1;  // Overrun happened
  localparam int          USA_INT_TXE        = 2;  // Transmit holding became empty
  localparam int          USA_INT_W          = 3;  // Interrupt width
  localparam int          USA_DATA_W         = 8;  // Character width
  localparam int          USA_DIV_W          = 16; // Divisor width

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [USA_CTRL_W-1:0] USA_CTRL_RST  = 2'h0;
  localparam logic [USA_DIV_W-1:0]  USA_DIV_RST   = 16'h00d9;
  localparam logic [USA_INT_W-1:0]  USA_IMASK_RST = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // FIFO geometry and infrared pulse shape
  localparam int          USA_FIFO_DEPTH     = 16;
  localparam int          USA_PTR_W          = 4;
  localparam int          USA_CNT_W          = 5;
  localparam logic [USA_CNT_W-1:0] USA_FIFO_FULL = USA_CNT_W'(USA_FIFO_DEPTH);
  localparam int          USA_IR_PULSE_NUM   = 3;  // Pulse is 3/16 of a bit
  localparam int          USA_IR_PULSE_SHIFT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // State machines
  typedef enum logic [1:0] {USA_RX_IDLE, USA_RX_START, USA_RX_DATA, USA_RX_STOP} usa_rx_state_t;
  typedef enum logic [2:0] {USA_TX_IDLE, USA_TX_LOAD, USA_TX_START, USA_TX_DATA, USA_TX_STOP} usa_tx_state_t;

endpackage

// ---- logic/usa_top.sv ----
// UART with shadow receive/transmit alias slots behind an AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
module usa_top
  import usa_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        sin,
  input  wire logic        sir_in,
  output logic             sout,
  output logic             sir_out_n,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                  sin_s1_r, sin_s2_r;     // Serial input synchroniser
  logic                  irin_s1_r, irin_s2_r;   // Infrared input synchroniser
  logic                  acc;                    // Address phase taken
  logic                  dp_wr_r;                // Write data phase
  logic [31:0]           dp_addr_r;              // Write address
  logic                  rd_wait_r;              // Read wait state
  logic [31:0]           rd_addr_r;              // Read address
  logic [31:0]           hrdata_r;               // Read data register
  logic [31:0]           rd_mux;                 // Read value being built
  logic [USA_CTRL_W-1:0] ctrl_r;                 // Mode control
  logic [USA_DIV_W-1:0]  div_r;                  // Bit period in clocks
  logic                  ovr_r;                  // Sticky overrun error
  logic [USA_INT_W-1:0]  istat_r;                // Interrupt status
  logic [USA_INT_W-1:0]  imask_r;                // Interrupt mask
  logic [USA_INT_W-1:0]  int_set;                // Interrupt events
  logic                  fifo_en, ir_mode;       // Mode bits
  logic                  flush;                  // FIFO mode change
  logic                  wr_ctrl, wr_istat;      // Register write strobes
  logic                  lstat_rd;               // Line status read
  logic [31:0]           lstat_val;              // Line status value
  logic                  rx_pop, rx_push;        // Receive FIFO strobes
  logic [USA_DATA_W-1:0] rx_rd_data;             // Receive FIFO head
  logic [USA_CNT_W-1:0]  rx_count;               // Receive FIFO fill
  logic                  rx_lost, rx_replaced;   // Receive losses
  logic                  tx_pop, tx_push;        // Transmit FIFO strobes
  logic [USA_DATA_W-1:0] tx_rd_data;             // Transmit FIFO head
  logic [USA_CNT_W-1:0]  tx_count;               // Transmit FIFO fill
  logic                  tx_holding_empty_flag, tx_empty_prev_r; // Holding-empty flag and history
  logic [USA_DIV_W-1:0]  ir_hold_r;              // Infrared pulse stretcher
  logic                  rx_line;                // Receive line after mode select
  usa_rx_state_t         rx_state_r;             // Receiver state
  logic [USA_DIV_W-1:0]  rx_cnt_r;               // Receiver bit timer
  logic [2:0]            rx_bit_r;               // Receiver bit index
  logic [USA_DATA_W-1:0] rx_sh_r;                // Receiver shifter
  usa_tx_state_t         tx_state_r;             // Transmitter state
  logic [USA_DIV_W-1:0]  tx_cnt_r;               // Transmitter bit timer
  logic [2:0]            tx_bit_r;               // Transmitter bit index
  logic [USA_DATA_W-1:0] tx_sh_r;                // Transmitter shifter
  logic                  tx_level;               // Current bit level
  logic [USA_DIV_W-1:0]  tx_elapsed;             // Clocks into the current bit
  logic [USA_DIV_W+1:0]  ir_prod;                // Divisor times pulse numerator
  logic [USA_DIV_W-1:0]  ir_pulse;               // Infrared pulse length
  logic                  sout_r, sir_out_n_r;    // Line output registers

  // Slot decode: any word in the sixteen-slot window
  function automatic logic is_alias(input logic [31:0] a);
    is_alias = (a >= USA_ALIAS_BASE) && (a < USA_ALIAS_BASE + USA_ALIAS_SPAN) && (a[1:0] == 2'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sin_s1_r  <= 1'b1;
      sin_s2_r  <= 1'b1;
      irin_s1_r <= 1'b1;
      irin_s2_r <= 1'b1;
    end else begin
      sin_s1_r  <= sin;
      sin_s2_r  <= sin_s1_r;
      irin_s1_r <= sir_in;
      irin_s2_r <= irin_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes take no wait, reads one wait state
  assign acc       = hsel && htrans[1] && hready;
  assign hreadyout = !rd_wait_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign fifo_en   = ctrl_r[USA_CTRL_FIFO_EN];
  assign ir_mode   = ctrl_r[USA_CTRL_IR_MODE];

  // Capture address phases
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= '0;
      rd_wait_r <= 1'b0;
      rd_addr_r <= '0;
    end else begin
      dp_wr_r   <= acc && hwrite;
      rd_wait_r <= acc && !hwrite;
      if (acc && hwrite) begin
        dp_addr_r <= haddr;
      end
      if (acc && !hwrite) begin
        rd_addr_r <= haddr;
      end
    end
  end

  // Alias read pops the receive head in its address phase
  assign rx_pop   = acc && !hwrite && is_alias(haddr);
  // Alias write pushes the low byte in its data phase
  assign tx_push  = dp_wr_r && is_alias(dp_addr_r);
  assign wr_ctrl  = dp_wr_r && (dp_addr_r == USA_CTRL_ADDR);
  assign wr_istat = dp_wr_r && (dp_addr_r == USA_ISTAT_ADDR);
  assign lstat_rd = rd_wait_r && (rd_addr_r == USA_LSTAT_ADDR);
  // Changing FIFO mode empties both queues
  assign flush    = wr_ctrl && (hwdata[USA_CTRL_FIFO_EN] != fifo_en);

  // Line status assembly
  always_comb begin
    lstat_val                    = '0;
    lstat_val[USA_LS_DATA_VALID] = (rx_count != '0);
    lstat_val[USA_LS_OVERRUN]    = ovr_r;
    lstat_val[USA_LS_TX_EMPTY]   = tx_holding_empty_flag;
    lstat_val[USA_LS_TX_IDLE]    = tx_holding_empty_flag && (tx_state_r == USA_TX_IDLE);
  end

  // Read value selection; unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    if (is_alias(rd_addr_r)) begin
      rd_mux[USA_DATA_W-1:0] = rx_rd_data;
    end else begin
      case (rd_addr_r)
        USA_CTRL_ADDR:  rd_mux[USA_CTRL_W-1:0] = ctrl_r;
        USA_LSTAT_ADDR: rd_mux = lstat_val;
        USA_DIV_ADDR:   rd_mux[USA_DIV_W-1:0] = div_r;
        USA_ISTAT_ADDR: rd_mux[USA_INT_W-1:0] = istat_r;
        USA_IMASK_ADDR: rd_mux[USA_INT_W-1:0] = imask_r;
        default:        rd_mux = '0;
      endcase
    end
  end

  // Read data register, loaded during the wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
    end else if (rd_wait_r) begin
      hrdata_r <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r  <= USA_CTRL_RST;
      div_r   <= USA_DIV_RST;
      imask_r <= USA_IMASK_RST;
    end else if (dp_wr_r) begin
      if (dp_addr_r == USA_CTRL_ADDR) begin
        ctrl_r <= hwdata[USA_CTRL_W-1:0];
      end
      if (dp_addr_r == USA_DIV_ADDR) begin
        div_r <= hwdata[USA_DIV_W-1:0];
      end
      if (dp_addr_r == USA_IMASK_ADDR) begin
        imask_r <= hwdata[USA_INT_W-1:0];
      end
    end
  end

  // Overrun error: set by any lost or replaced receive byte, cleared by a line status read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovr_r <= 1'b0;
    end else if (rx_lost || rx_replaced) begin
      ovr_r <= 1'b1;
    end else if (lstat_rd) begin
      ovr_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky events, write one to clear, new event wins
  assign int_set[USA_INT_RX]  = rx_push;
  assign int_set[USA_INT_OVR] = rx_lost || rx_replaced;
  assign int_set[USA_INT_TXE] = tx_holding_empty_flag && !tx_empty_prev_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_r     <= '0;
      tx_empty_prev_r <= 1'b1;
    end else begin
      tx_empty_prev_r <= tx_holding_empty_flag;
      istat_r     <= int_set | (istat_r & ~(wr_istat ? hwdata[USA_INT_W-1:0] : '0));
    end
  end

  assign irq = |(istat_r & imask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Receive and transmit queues
  usa_fifo u_rx_fifo (
    .clk       (hclk),
    .rst_n     (hresetn),
    .flush     (flush),
    .fifo_en   (fifo_en),
    .push      (rx_push),
    .push_data (rx_sh_r),
    .pop       (rx_pop),
    .rd_data   (rx_rd_data),
    .count     (rx_count),
    .lost      (rx_lost),
    .replaced  (rx_replaced)
  );

  // Transmit queue: full drops the write, single-entry mode replaces
  usa_fifo u_tx_fifo (
    .clk       (hclk),
    .rst_n     (hresetn),
    .flush     (flush),
    .fifo_en   (fifo_en),
    .push      (tx_push),
    .push_data (hwdata[USA_DATA_W-1:0]),
    .pop       (tx_pop),
    .rd_data   (tx_rd_data),
    .count     (tx_count),
    .lost      (),
    .replaced  ()
  );

  // Holding empty while nothing waits to be sent
  assign tx_holding_empty_flag = (tx_count == '0);

  ////////////////////////////////////////////////////////////////////////////
  // Infrared receive: each low pulse holds the line low until one bit period after the pulse ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_hold_r <= '0;
    end else if (!irin_s2_r) begin
      ir_hold_r <= div_r;
    end else if (ir_hold_r != '0) begin
      ir_hold_r <= ir_hold_r - 1'b1;
    end
  end

  assign rx_line = ir_mode ? !(!irin_s2_r || (ir_hold_r != '0)) : sin_s2_r;

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: start, eight data bits LSB first, one stop, mid-bit sampling
  assign rx_push = (rx_state_r == USA_RX_STOP) && (rx_cnt_r == '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_r <= USA_RX_IDLE;
      rx_cnt_r   <= '0;
      rx_bit_r   <= '0;
      rx_sh_r    <= '0;
    end else begin
      case (rx_state_r)
        USA_RX_IDLE: begin
          // Falling edge opens a frame
          if (!rx_line) begin
            rx_state_r <= USA_RX_START;
            rx_cnt_r   <= div_r >> 1;
          end
        end
        USA_RX_START: begin
          // Confirm start bit at its middle
          if (rx_cnt_r != '0) begin
            rx_cnt_r <= rx_cnt_r - 1'b1;
          end else if (!rx_line) begin
            rx_state_r <= USA_RX_DATA;
            rx_cnt_r   <= div_r - 1'b1;
            rx_bit_r   <= '0;
          end else begin
            rx_state_r <= USA_RX_IDLE;
          end
        end
        USA_RX_DATA: begin
          // Shift in one bit per period
          if (rx_cnt_r != '0) begin
            rx_cnt_r <= rx_cnt_r - 1'b1;
          end else begin
            rx_sh_r  <= {rx_line, rx_sh_r[USA_DATA_W-1:1]};
            rx_cnt_r <= div_r - 1'b1;
            rx_bit_r <= rx_bit_r + 1'b1;
            if (rx_bit_r == 3'h7) begin
              rx_state_r <= USA_RX_STOP;
            end
          end
        end
        USA_RX_STOP: begin
          // Character handed to the queue at mid stop bit
          if (rx_cnt_r != '0) begin
            rx_cnt_r <= rx_cnt_r - 1'b1;
          end else begin
            rx_state_r <= USA_RX_IDLE;
          end
        end
        default: rx_state_r <= USA_RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter: takes the head when idle, then frames it
  assign tx_pop = (tx_state_r == USA_TX_IDLE) && (tx_count != '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state_r <= USA_TX_IDLE;
      tx_cnt_r   <= '0;
      tx_bit_r   <= '0;
      tx_sh_r    <= '0;
    end else begin
      case (tx_state_r)
        USA_TX_IDLE: begin
          // Head read is issued by the pop this cycle
          if (tx_count != '0) begin
            tx_state_r <= USA_TX_LOAD;
          end
        end
        USA_TX_LOAD: begin
          // Registered head arrives one cycle after the pop
          tx_sh_r    <= tx_rd_data;
          tx_cnt_r   <= div_r - 1'b1;
          tx_state_r <= USA_TX_START;
        end
        USA_TX_START: begin
          if (tx_cnt_r != '0) begin
            tx_cnt_r <= tx_cnt_r - 1'b1;
          end else begin
            tx_cnt_r   <= div_r - 1'b1;
            tx_bit_r   <= '0;
            tx_state_r <= USA_TX_DATA;
          end
        end
        USA_TX_DATA: begin
          if (tx_cnt_r != '0) begin
            tx_cnt_r <= tx_cnt_r - 1'b1;
          end else begin
            tx_sh_r  <= tx_sh_r >> 1;
            tx_cnt_r <= div_r - 1'b1;
            tx_bit_r <= tx_bit_r + 1'b1;
            if (tx_bit_r == 3'h7) begin
              tx_state_r <= USA_TX_STOP;
            end
          end
        end
        USA_TX_STOP: begin
          if (tx_cnt_r != '0) begin
            tx_cnt_r <= tx_cnt_r - 1'b1;
          end else begin
            tx_state_r <= USA_TX_IDLE;
          end
        end
        default: tx_state_r <= USA_TX_IDLE;
      endcase
    end
  end

  // Bit level: low for start, data LSB first, high otherwise
  always_comb begin
    case (tx_state_r)
      USA_TX_START: tx_level = 1'b0;
      USA_TX_DATA:  tx_level = tx_sh_r[0];
      default:      tx_level = 1'b1;
    endcase
  end

  // Infrared pulse is a short low at the start of each zero bit
  assign tx_elapsed = div_r - 1'b1 - tx_cnt_r;
  assign ir_prod    = (USA_DIV_W + 2)'(div_r) * (USA_DIV_W + 2)'(USA_IR_PULSE_NUM);
  assign ir_pulse   = USA_DIV_W'(ir_prod >> USA_IR_PULSE_SHIFT);

  // Registered line outputs; the unused line rests high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sout_r      <= 1'b1;
      sir_out_n_r <= 1'b1;
    end else begin
      sout_r      <= ir_mode ? 1'b1 : tx_level;
      sir_out_n_r <= !(ir_mode && !tx_level && (tx_elapsed <= ir_pulse));
    end
  end

  assign sout      = sout_r;
  assign sir_out_n = sir_out_n_r;

endmodule
`default_nettype wire

// ---- sim/usa_checker.sv ----
// Port-level assertions for the shadow alias UART
`timescale 1ns/1ps
`default_nettype none
module usa_checker
  import usa_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        sout,
  input wire logic        sir_out_n
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic tk = hsel & htrans[1] & hready;             // Transfer taken
  wire logic al = (haddr - USA_ALIAS_BASE) < USA_ALIAS_SPAN; // Alias slot hit
  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  a_read_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait");
  a_write_nowait: assert property (tk && hwrite |=> hreadyout) else $error("write wait");
  a_wait_cause: assert property (!hreadyout |-> $past(tk && !hwrite)) else $error("stray wait");
  a_wait_single: assert property (!hreadyout |=> hreadyout) else $error("long wait");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata)) else $error("hrdata moved");
  a_upper_zero: assert property (tk && !hwrite && al |=> ##1 hrdata[31:8] == 24'h0) else $error("upper bits");
  a_lines_apart: assert property (sout || sir_out_n) else $error("both lines low");
  a_start_bit: assert property ($fell(sout) |-> !sout [*4]) else $error("short start bit");
endmodule
`default_nettype wire

// ---- sim/usa_line_model.sv ----
// Serial line partner: drives receive lines, decodes sout and counts sir_out_n pulses
`timescale 1ns/1ps
`default_nettype none
module usa_line_model #(parameter int D = 8) (
  input  wire logic hclk,
  input  wire logic sout,
  input  wire logic sir_out_n,
  output var  logic sin,
  output var  logic sir_in
);
  logic [15:0] got = 16'h0; // Last two decoded characters
  logic [7:0]  b;           // Character being decoded
  int          cnt = 0;     // Characters decoded on sout
  int          pul = 0;     // Infrared pulses seen
  initial begin sin = 1'b1; sir_in = 1'b1; end // Both lines idle high
  // Sends one 8N1 frame, LSB first, on the chosen line
  task automatic send(input logic [7:0] v, input logic ir);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      if (ir) begin sir_in <= f[i]; repeat (2) @(posedge hclk); sir_in <= 1'b1; repeat (D - 2) @(posedge hclk); end
      else begin sin <= f[i]; repeat (D) @(posedge hclk); end
    end
  endtask
  // Decodes sout frames at mid bit
  initial forever begin
    @(negedge sout);
    repeat (D / 2) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin repeat (D) @(posedge hclk); b[i] = sout; end
    got = {got[7:0], b};
    cnt++;
    repeat (D) @(posedge hclk);
  end
  always @(negedge sir_out_n) pul++; // Counts zero-bit pulses
endmodule
`default_nettype wire

// ---- sim/usa_top_test.sv ----
// Bench for the shadow alias UART
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, s) begin checks++; if ((s) !== (e)) begin miscompares++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module usa_top_test
  import usa_pkg::*;
;
  localparam int D = 8;                      // Bit period in clocks
  logic        hclk = 1'b0, hresetn = 1'b0; // Clock and reset
  logic        hsel = 1'b0, hwrite = 1'b0;  // Bus controls
  logic [1:0]  htrans = 2'h0;               // Transfer type
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q; // Address, write data, read result
  wire  logic  hreadyout, hresp, sout, sir_out_n, irq, sin, sir_in;
  wire  logic [31:0] hrdata;
  int          miscompares = 0, checks = 0;
  usa_top u_usa_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sin, .sir_in, .sout, .sir_out_n, .irq);
  usa_line_model #(.D(D)) u_usa_line_model (.hclk, .sout, .sir_out_n, .sin, .sir_in);
  initial forever #20 hclk = ~hclk; // 25 MHz clock
  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Waits for an edge with hready high, bounded
  task automatic wt;
    int n;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin miscompares++; conclude; end
  endtask
  // One single AHB-Lite transfer; read data lands in q
  task automatic bus(input logic w, input logic [31:0] a, d);
    {haddr, hwrite, htrans} <= {a, w, 2'h2};
    wt;
    {htrans, hwdata} <= {2'h0, d};
    wt;
    q = hrdata;
  endtask
  task automatic rc(input logic [31:0] a, e);
    bus(1'b0, a, 32'h0);
    `CK($sformatf("reg %h", a), e, q)
  endtask
  // Waits until the line model has seen c characters or pulses
  task automatic wc(input int c, input logic ir);
    int n;
    for (n = 0; n < 3000 && (ir ? u_usa_line_model.pul : u_usa_line_model.cnt) < c; n++) @(posedge hclk);
    if (n >= 3000) begin miscompares++; conclude; end
  endtask
  task automatic t_reset;
    rc(USA_LSTAT_ADDR, 32'h60);
    rc(USA_CTRL_ADDR, 32'h0);
    rc(USA_DIV_ADDR, 32'h00d9);
    rc(USA_IMASK_ADDR, 32'h0);
    rc(USA_SLOT9_ADDR, 32'h0);
    rc(32'h5000_1200, 32'h0);
    bus(1'b1, USA_DIV_ADDR, 32'(D));
  endtask
  task automatic t_rx_off;
    u_usa_line_model.send(8'h5a, 1'b0);
    u_usa_line_model.send(8'hc3, 1'b0);
    rc(USA_LSTAT_ADDR, 32'h63);
    rc(USA_ALIAS_BASE + 32'h3c, 32'hc3);
    rc(USA_ISTAT_ADDR, 32'h3);
    `CK("irq", 1'b0, irq)
    bus(1'b1, USA_IMASK_ADDR, 32'h2);
    rc(USA_LSTAT_ADDR, 32'h60);
    `CK("irq", 1'b1, irq)
    bus(1'b1, USA_ISTAT_ADDR, 32'h3);
    rc(USA_ISTAT_ADDR, 32'h0);
    `CK("irq", 1'b0, irq)
  endtask
  task automatic t_rx_fifo;
    bus(1'b1, USA_CTRL_ADDR, 32'h3);
    for (int i = 0; i < 17; i++) u_usa_line_model.send(8'(i + 8'h81), 1'b1);
    rc(USA_LSTAT_ADDR, 32'h63);
    for (int i = 0; i < 16; i++) rc(USA_ALIAS_BASE + 32'(4 * i), 32'(i + 8'h81));
    rc(USA_LSTAT_ADDR, 32'h60);
  endtask
  task automatic t_tx_off;
    bus(1'b1, USA_CTRL_ADDR, 32'h0);
    bus(1'b1, USA_SLOT8_ADDR, 32'hffff_ff11);
    bus(1'b1, USA_SLOT9_ADDR, 32'h22);
    bus(1'b1, USA_SLOT9_ADDR, 32'h33);
    rc(USA_LSTAT_ADDR, 32'h0);
    wc(2, 1'b0);
    `CK("sout bytes", 16'h1133, u_usa_line_model.got)
  endtask
  task automatic t_tx_fifo;
    repeat (2 * D) @(posedge hclk);
    bus(1'b1, USA_CTRL_ADDR, 32'h3);
    // Last write meets a full queue; its all-ones byte would change the pulse count if kept
    for (int i = 0; i < 18; i++) bus(1'b1, USA_ALIAS_BASE + 32'(4 * (i % 16)), (i == 17) ? 32'hff : 32'h0);
    rc(USA_LSTAT_ADDR, 32'h0);
    wc(153, 1'b1);
    repeat (200) @(posedge hclk);
    `CK("ir pulses", 153, u_usa_line_model.pul)
    // Receive, overrun and holding-empty events all left sticky since the last clear
    rc(USA_ISTAT_ADDR, 32'h7);
    `CK("irq", 1'b1, irq)
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    t_reset;
    t_rx_off;
    t_rx_fifo;
    t_tx_off;
    t_tx_fifo;
    conclude;
  end
endmodule
bind usa_top usa_checker u_usa_checker (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .sout, .sir_out_n);
`default_nettype wire
